// File: hw/cluster_pkg.sv
// Constants, field layouts and carrier types of the logic cluster
package cluster_pkg;
	localparam int ADDR_W    = 8;
	localparam int CELLS     = 8;
	localparam int LINES     = 3;
	localparam int ROW_CLKS  = 6;
	localparam int LUT_WORDS = CELLS * 4;
	localparam logic [ADDR_W-1:0] CLK_CFG_OFS  = 8'h00;
	localparam logic [ADDR_W-1:0] CTL_CFG_OFS  = 8'h04;
	localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h08;
	localparam logic [ADDR_W-1:0] REG_Q_OFS    = 8'h0c;
	localparam logic [ADDR_W-1:0] CELL_CFG_OFS = 8'h20;
	localparam logic [ADDR_W-1:0] CELL_CFG_END = 8'h3c;
	localparam logic [ADDR_W-1:0] LUT_OFS      = 8'h40;
	localparam logic [ADDR_W-1:0] LUT_END      = 8'hbc;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;
	localparam logic [31:0] RESET_WORD = 32'h0;
	// Local interconnect control line positions
	localparam int LOC_ACLR0 = 3;
	localparam int LOC_ACLR1 = 4;
	localparam int LOC_SCLR  = 5;
	localparam int LOC_ALOAD = 6;
	localparam int LOC_SLOAD = 7;
	// Line enables sit above the three line fields; gate-use bits live in
	// the control word so they never overlap line two's source field
	localparam int LINE_EN_POS  = 12;
	localparam int GATE_USE_POS = 8;
	localparam logic [2:0] SRC_LOCAL0 = 3'h6;
	localparam logic [2:0] SRC_LOCAL1 = 3'h7;
	localparam logic [1:0] CLK_NONE  = 2'h3;
	localparam logic [1:0] ACLR_NONE = 2'h0;
	localparam logic [1:0] ACLR_ZERO = 2'h1;
	localparam logic [1:0] ACLR_ONE  = 2'h2;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_EXT    = 2'b01,
		MODE_ARITH  = 2'b10,
		MODE_SHARED = 2'b11
	} cell_mode_t;

	typedef enum logic [1:0] {
		SUB_SIX     = 2'b00,
		SUB_FOUR4   = 2'b01,
		SUB_FIVE3   = 2'b10,
		SUB_FIVE5   = 2'b11
	} normal_sub_t;

	typedef enum logic [1:0] {
		DSEL_LUT   = 2'b00,
		DSEL_PACK  = 2'b01,
		DSEL_CHAIN = 2'b10,
		DSEL_RSVD  = 2'b11
	} data_sel_t;

	typedef struct packed {
		logic       sload_use;
		logic       sclr_use;
		logic [1:0] aclr_sel;
		logic [1:0] clk_sel;
		data_sel_t  data_sel;
	} reg_cfg_t;

	// Cell configuration word, low bits first from the bottom of the struct
	typedef struct packed {
		logic [4:0]  unused;
		logic [3:0]  out_reg;
		reg_cfg_t    reg1;
		reg_cfg_t    reg0;
		logic        aload_f1;
		logic        aload_f0;
		logic        feedback;
		normal_sub_t sub;
		cell_mode_t  mode;
	} cell_cfg_t;

	typedef struct packed {
		logic       falling;
		logic [2:0] src;
	} line_cfg_t;

	// Data bits: 0 a, 1 b, 2 c, 3 d, 4 e0, 5 f0, 6 e1, 7 f1
	typedef struct packed {
		logic       chain_in;
		logic       shared_in;
		logic       carry_in;
		logic [7:0] data;
	} cell_in_t;

	typedef struct packed {
		logic [1:0] bottom;
		logic [1:0] top;
	} cell_out_t;
endpackage

// File: hw/logic_cluster.sv
// Logic cluster: control signal generator, eight adaptive cells, AXI4-Lite
// Summary of operation
// - Cluster makes three clocks, three gates, two clears, sclr, aload, sload.
// - At most two distinct source clocks; a third distinct source is refused.
// - Each cluster clock line is governed by its own clock gate.
// - A deasserted gate stops its line; registers on it hold.
// - Both edges of one source use two clock lines.
// - Asynchronous load with its data input high presets the register.
// - While asynchronous load is in use, clock gate zero is ignored.
// - Control signals come from six row clocks and local interconnect.
// - Each cell has two registers with full control inputs.
// - Asynchronous load data comes from the e or f data input.
// - Combinational functions bypass the register to the cell outputs.
// - Each half drives two outputs; top one also serves local routing.
// - Register feeds its own LUT; registered and unregistered results out.
// - Eleven cell inputs: eight data, carry, shared chain, register chain.
// - One of four modes per cell; register controls work in all.
// - Normal mode: two functions of eight inputs or one six-input one.
// - Two independent four-input, or five plus three, share nothing.
// - Two five-input functions share a and b.
// - Two six-input functions share a to d; each has its own LUT mask.
// - Pair zero goes to register zero/top, pair one to register one/bottom.
// - f1 packing only while the six-input result is unregistered.
module logic_cluster
	import cluster_pkg::*;
(
	input  wire logic                        core_clk,
	input  wire logic                        reset_n,
	input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [ADDR_W-1:0]           s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic [ROW_CLKS-1:0]         row_clk,
	input  wire logic [7:0]                  local_ctl,
	input  wire cluster_pkg::cell_in_t [CELLS-1:0] cell_in,
	output cluster_pkg::cell_out_t [CELLS-1:0]     cell_out
);
	import cluster_pkg::*;

	logic [31:0]             clk_cfg_r;
	logic [31:0]             ctl_cfg_r;
	logic [31:0]             cell_cfg_r [CELLS];
	logic [31:0]             lut_r [LUT_WORDS];
	logic [ADDR_W-1:0]       awaddr_r;
	logic [31:0]             wdata_r;
	logic [3:0]              wstrb_r;
	logic                    aw_got_r;
	logic                    w_got_r;
	logic                    wr_go;
	logic [31:0]             rd_word;
	logic                    rd_hit;
	logic [LINES-1:0]        src_lvl;
	logic [LINES-1:0]        src_d_r;
	logic [LINES-1:0]        line_ok;
	logic [LINES-1:0]        gate;
	logic [LINES-1:0]        tick;
	logic                    aclr0;
	logic                    aclr1;
	logic                    sclr;
	logic                    sload;
	logic                    aload;
	logic [2*CELLS-1:0]      q_all;
	logic [CELLS-1:0]        deny_all;
	line_cfg_t               lc [LINES];

	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Register bus: write address and data are caught in either order
	assign wr_go = aw_got_r && w_got_r && !s_axi_bvalid;

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			aw_got_r      <= 1'b0;
			s_axi_awready <= 1'b1;
			awaddr_r      <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_got_r      <= 1'b1;
			s_axi_awready <= 1'b0;
			awaddr_r      <= s_axi_awaddr;
		end else if (wr_go) begin
			aw_got_r      <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			w_got_r      <= 1'b0;
			s_axi_wready <= 1'b1;
			wdata_r      <= '0;
			wstrb_r      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_got_r      <= 1'b1;
			s_axi_wready <= 1'b0;
			wdata_r      <= s_axi_wdata;
			wstrb_r      <= s_axi_wstrb;
		end else if (wr_go) begin
			w_got_r      <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			if (awaddr_r == CLK_CFG_OFS || awaddr_r == CTL_CFG_OFS ||
					(awaddr_r >= CELL_CFG_OFS && awaddr_r <= LUT_END &&
					awaddr_r[1:0] == 2'b00)) begin
				s_axi_bresp <= RESP_OKAY;
			end else begin
				s_axi_bresp <= RESP_DECERR;
			end
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			clk_cfg_r <= RESET_WORD;
			ctl_cfg_r <= RESET_WORD;
			for (int i = 0; i < CELLS; i++) begin
				cell_cfg_r[i] <= RESET_WORD;
			end
			for (int i = 0; i < LUT_WORDS; i++) begin
				lut_r[i] <= RESET_WORD;
			end
		end else if (wr_go && awaddr_r[1:0] == 2'b00) begin
			if (awaddr_r == CLK_CFG_OFS) begin
				clk_cfg_r <= merge(clk_cfg_r, wdata_r, wstrb_r);
			end else if (awaddr_r == CTL_CFG_OFS) begin
				ctl_cfg_r <= merge(ctl_cfg_r, wdata_r, wstrb_r);
			end else if (awaddr_r >= CELL_CFG_OFS && awaddr_r <= CELL_CFG_END) begin
				cell_cfg_r[awaddr_r[4:2]] <= merge(cell_cfg_r[awaddr_r[4:2]],
					wdata_r, wstrb_r);
			end else if (awaddr_r >= LUT_OFS && awaddr_r <= LUT_END) begin
				lut_r[5'(awaddr_r[7:2] - LUT_OFS[7:2])] <= merge(
					lut_r[5'(awaddr_r[7:2] - LUT_OFS[7:2])], wdata_r, wstrb_r);
			end
		end
	end

	always_comb begin
		rd_hit  = 1'b1;
		rd_word = '0;
		if (s_axi_araddr[1:0] != 2'b00) begin
			rd_hit = 1'b0;
		end else if (s_axi_araddr == CLK_CFG_OFS) begin
			rd_word = clk_cfg_r;
		end else if (s_axi_araddr == CTL_CFG_OFS) begin
			rd_word = ctl_cfg_r;
		end else if (s_axi_araddr == STATUS_OFS) begin
			rd_word = {16'h0, deny_all, 2'h0, ~line_ok[2],
				aload, src_d_r, 1'b0};
		end else if (s_axi_araddr == REG_Q_OFS) begin
			rd_word = {16'h0, q_all};
		end else if (s_axi_araddr >= CELL_CFG_OFS && s_axi_araddr <= CELL_CFG_END) begin
			rd_word = cell_cfg_r[s_axi_araddr[4:2]];
		end else if (s_axi_araddr >= LUT_OFS && s_axi_araddr <= LUT_END) begin
			rd_word = lut_r[5'(s_axi_araddr[7:2] - LUT_OFS[7:2])];
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_DECERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Cluster-wide control signals from local lines, each with its enable
	assign aclr0 = ctl_cfg_r[LOC_ACLR0] && local_ctl[LOC_ACLR0];
	assign aclr1 = ctl_cfg_r[LOC_ACLR1] && local_ctl[LOC_ACLR1];
	assign sclr  = ctl_cfg_r[LOC_SCLR]  && local_ctl[LOC_SCLR];
	assign aload = ctl_cfg_r[LOC_ALOAD] && local_ctl[LOC_ALOAD];
	assign sload = ctl_cfg_r[LOC_SLOAD] && local_ctl[LOC_SLOAD];

	// Clock line 2 is refused when it would be a third distinct source
	assign line_ok[0] = 1'b1;
	assign line_ok[1] = 1'b1;
	assign line_ok[2] = !(&clk_cfg_r[LINE_EN_POS +: 2] &&
		lc[0].src != lc[1].src && lc[2].src != lc[0].src &&
		lc[2].src != lc[1].src);

	generate
		for (genvar l = 0; l < LINES; l++) begin : g_line
			assign lc[l] = line_cfg_t'(clk_cfg_r[l*4 +: 4]);
			// Row clocks are sampled; lines pulse once per chosen edge
			assign src_lvl[l] = (lc[l].src == SRC_LOCAL0) ? local_ctl[0] :
				(lc[l].src == SRC_LOCAL1) ? local_ctl[1] :
				row_clk[lc[l].src];
			if (l == 0) begin : g_gate0
				// Gate zero is dropped (held open) while aload is asserted
				assign gate[l] = aload || !ctl_cfg_r[GATE_USE_POS + l] ||
					local_ctl[l];
			end else begin : g_gaten
				assign gate[l] = !ctl_cfg_r[GATE_USE_POS + l] || local_ctl[l];
			end
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					src_d_r[l] <= 1'b0;
				end else begin
					src_d_r[l] <= src_lvl[l];
				end
			end
			// Each line has its own edge, so one source on both edges takes two
			assign tick[l] = clk_cfg_r[LINE_EN_POS + l] && line_ok[l] &&
				gate[l] && (lc[l].falling ? (src_d_r[l] && !src_lvl[l]) :
				(!src_d_r[l] && src_lvl[l]));
		end
	endgenerate

	generate
		for (genvar k = 0; k < CELLS; k++) begin : g_cell
			cell_cfg_t   cfg;
			logic [7:0]  din;
			logic [63:0] mask0;
			logic [63:0] mask1;
			logic [5:0]  idx0;
			logic [5:0]  idx1;
			logic [1:0]  lut;
			logic [1:0]  res;
			logic [1:0]  q_r;
			logic [1:0]  dnext;
			logic [1:0]  ald;
			logic        deny;
			cell_out_t   out_r;

			assign cfg   = cell_cfg_t'(cell_cfg_r[k]);
			assign mask0 = {lut_r[k*4+1], lut_r[k*4]};
			assign mask1 = {lut_r[k*4+3], lut_r[k*4+2]};
			// Eight data inputs; d may be swapped for the cell's own register
			assign din = {cell_in[k].data[7:4],
				cfg.feedback ? q_r[0] : cell_in[k].data[3],
				cell_in[k].data[2:0]};

			always_comb begin
				idx0 = {din[5], din[4], din[3:0]};
				idx1 = {din[7], din[6], din[3:0]};
				if (cfg.mode == MODE_NORMAL) begin
					case (cfg.sub)
						SUB_SIX: begin
							idx0 = {din[5], din[4], din[3:0]};
							idx1 = {din[7], din[6], din[3:0]};
						end
						SUB_FOUR4: begin
							idx0 = {2'b00, din[3:0]};
							idx1 = {2'b00, din[7:4]};
						end
						SUB_FIVE3: begin
							idx0 = {1'b0, din[4:0]};
							idx1 = {3'b000, din[7:5]};
						end
						SUB_FIVE5: begin
							idx0 = {1'b0, din[4:0]};
							idx1 = {1'b0, din[7:5], din[1:0]};
						end
						default: begin
							idx0 = '0;
							idx1 = '0;
						end
					endcase
				end
				lut = {mask1[idx1], mask0[idx0]};
				case (cfg.mode)
					MODE_EXT:    res = {lut[1], din[7] ? lut[1] : lut[0]};
					MODE_ARITH:  res = lut ^ {lut[0] & cell_in[k].carry_in,
						cell_in[k].carry_in};
					MODE_SHARED: res = lut ^ {lut[0] & cell_in[k].shared_in,
						cell_in[k].shared_in};
					default:     res = lut;
				endcase
			end

			// f1 cannot be packed into register 1 while register 0 stores the six-input LUT result
			assign deny = cfg.mode == MODE_NORMAL && cfg.sub == SUB_SIX &&
				cfg.reg1.data_sel == DSEL_PACK &&
				cfg.reg0.data_sel == DSEL_LUT &&
				cfg.reg0.clk_sel != CLK_NONE;

			always_comb begin
				dnext[0] = res[0];
				dnext[1] = res[1];
				if (cfg.reg0.data_sel == DSEL_PACK) begin
					dnext[0] = din[5];
				end else if (cfg.reg0.data_sel == DSEL_CHAIN) begin
					dnext[0] = cell_in[k].chain_in;
				end
				if (cfg.reg1.data_sel == DSEL_PACK && !deny) begin
					dnext[1] = din[7];
				end else if (cfg.reg1.data_sel == DSEL_CHAIN) begin
					dnext[1] = q_r[0];
				end
				ald[0] = cfg.aload_f0 ? din[5] : din[4];
				ald[1] = cfg.aload_f1 ? din[7] : din[6];
			end

			for (genvar r = 0; r < 2; r++) begin : g_reg
				reg_cfg_t rc;
				logic     clr;
				logic     clk_en;

				assign rc = (r == 0) ? cfg.reg0 : cfg.reg1;
				assign clr = (rc.aclr_sel == ACLR_ZERO && aclr0) ||
					(rc.aclr_sel == ACLR_ONE && aclr1);
				assign clk_en = rc.clk_sel != CLK_NONE && tick[rc.clk_sel];

				always_ff @(posedge core_clk or negedge reset_n) begin
					if (!reset_n) begin
						q_r[r] <= 1'b0;
					end else if (clr) begin
						q_r[r] <= 1'b0;
					end else if (aload) begin
						q_r[r] <= ald[r];
					end else if (clk_en) begin
						if (rc.sclr_use && sclr) begin
							q_r[r] <= 1'b0;
						end else if (rc.sload_use && sload) begin
							q_r[r] <= din[2];
						end else begin
							q_r[r] <= dnext[r];
						end
					end
				end
			end

			// Each output picks register or bypassed LUT independently
			always_ff @(posedge core_clk or negedge reset_n) begin
				if (!reset_n) begin
					out_r <= '0;
				end else begin
					for (int o = 0; o < 2; o++) begin
						out_r.top[o] <= cfg.out_reg[o] ? q_r[0] :
							res[0];
						out_r.bottom[o] <= cfg.out_reg[2 + o] ? q_r[1] :
							res[1];
					end
				end
			end

			assign cell_out[k]        = out_r;
			assign q_all[k*2 +: 2]    = q_r;
			assign deny_all[k]        = deny;
		end
	endgenerate
endmodule

// File: verif/logic_cluster_monitor.sv
// Port checker of the logic cluster: bus handshakes and cell output holding
module logic_cluster_monitor
	import cluster_pkg::*;
(
	input wire logic                            core_clk,
	input wire logic                            reset_n,
	input wire logic [ADDR_W-1:0]               s_axi_awaddr,
	input wire logic                            s_axi_awvalid,
	input wire logic                            s_axi_awready,
	input wire logic                            s_axi_wvalid,
	input wire logic                            s_axi_wready,
	input wire logic [1:0]                      s_axi_bresp,
	input wire logic                            s_axi_bvalid,
	input wire logic                            s_axi_bready,
	input wire logic [ADDR_W-1:0]               s_axi_araddr,
	input wire logic                            s_axi_arvalid,
	input wire logic                            s_axi_arready,
	input wire logic [31:0]                     s_axi_rdata,
	input wire logic [1:0]                      s_axi_rresp,
	input wire logic                            s_axi_rvalid,
	input wire logic                            s_axi_rready,
	input wire logic [ROW_CLKS-1:0]             row_clk,
	input wire logic [7:0]                      local_ctl,
	input wire cluster_pkg::cell_in_t [CELLS-1:0]  cell_in,
	input wire cluster_pkg::cell_out_t [CELLS-1:0] cell_out
);
	import cluster_pkg::*;

	logic [1:0] quiet_r;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);

	// Config writes also move the outputs, so a write answer ends a quiet run
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			quiet_r <= 2'h0;
		end else if ($changed(row_clk) || $changed(local_ctl)
				|| $changed(cell_in) || s_axi_bvalid) begin
			quiet_r <= 2'h0;
		end else if (quiet_r != 2'h3) begin
			quiet_r <= quiet_r + 2'h1;
		end
	end

	AST_HOLD_QUIET:
		assert property (quiet_r == 2'h3 |-> $stable(cell_out))
		else $error("cell outputs moved with no tick or input change");
	AST_WR_ANSWER:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
			&& s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two edges after the take");
	AST_WR_RO:
		assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
			&& s_axi_wready && s_axi_awaddr == STATUS_OFS
			|-> ##2 s_axi_bresp == RESP_DECERR)
		else $error("write to status not refused");
	AST_B_HOLD:
		assert property (s_axi_bvalid && !s_axi_bready
			|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped before bready");
	AST_AW_BLOCK:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel open while answer pending");
	AST_RD_ANSWER:
		assert property (s_axi_arvalid && s_axi_arready
			|=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer not one edge after the take");
	AST_R_HOLD:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
			&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read answer changed before rready");
	AST_R_RELEASE:
		assert property (s_axi_rvalid && s_axi_rready
			|=> !s_axi_rvalid && s_axi_arready)
		else $error("read channel not reopened after handshake");
	AST_RD_DECERR:
		assert property (s_axi_arvalid && s_axi_arready
			&& s_axi_araddr inside {[8'h10:8'h1f]}
			|=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
endmodule

bind logic_cluster logic_cluster_monitor MON (
	.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .row_clk, .local_ctl,
	.cell_in, .cell_out
);

// File: verif/tb_logic_cluster.sv
// Testbench of the logic cluster: register bus and cell behaviour
module tb_logic_cluster
	import cluster_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic                     core_clk      = 1'b0;
	logic                     reset_n       = 1'b0;
	logic [ADDR_W-1:0]        s_axi_awaddr  = '0;
	logic                     s_axi_awvalid = 1'b0;
	logic [31:0]              s_axi_wdata   = '0;
	logic                     s_axi_wvalid  = 1'b0;
	logic                     s_axi_bready  = 1'b0;
	logic [ADDR_W-1:0]        s_axi_araddr  = '0;
	logic                     s_axi_arvalid = 1'b0;
	logic                     s_axi_rready  = 1'b0;
	logic [ROW_CLKS-1:0]      row_clk       = '0;
	logic [7:0]               local_ctl     = '0;
	cell_in_t [CELLS-1:0]     cell_in       = '0;
	logic                     s_axi_awready;
	logic                     s_axi_wready;
	logic [1:0]               s_axi_bresp;
	logic                     s_axi_bvalid;
	logic                     s_axi_arready;
	logic [31:0]              s_axi_rdata;
	logic [1:0]               s_axi_rresp;
	logic                     s_axi_rvalid;
	cell_out_t [CELLS-1:0]    cell_out;
	int                       mismatches    = 0;
	int                       tests_run     = 0;

	// Rows: local controls, cell 0 data, row clock tick, expected outputs
	localparam logic [20:0] STEPS [13] = '{
		{8'h01, 8'h01, 1'b0, 4'h1},
		{8'h01, 8'h02, 1'b0, 4'hc},
		{8'h01, 8'h23, 1'b0, 4'hc},
		{8'h01, 8'h82, 1'b0, 4'h0},
		{8'h01, 8'h01, 1'b1, 4'h3},
		{8'h00, 8'h00, 1'b1, 4'h2},
		{8'h81, 8'h01, 1'b1, 4'h1},
		{8'h81, 8'h04, 1'b1, 4'h2},
		{8'ha1, 8'h05, 1'b1, 4'h1},
		{8'h01, 8'h01, 1'b1, 4'h3},
		{8'h08, 8'h01, 1'b0, 4'h1},
		{8'h40, 8'h10, 1'b0, 4'h2},
		{8'h01, 8'h00, 1'b0, 4'h2}
	};

	logic_cluster DUT (
		.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .row_clk, .local_ctl, .cell_in,
		.cell_out
	);

	always #25 core_clk = ~core_clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] er);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge core_clk);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
		// One idle edge so the next request never lands in this time step
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m,
			input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge core_clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		chk(s_axi_rdata & m, e);
		chk({30'h0, s_axi_rresp}, {30'h0, er});
		@(posedge core_clk);
	endtask

	// Data settles before the tick so the LUT result is stable when loaded
	task automatic step(input logic [20:0] s);
		local_ctl <= s[20:13];
		cell_in[0].data <= s[12:5];
		repeat (2) @(posedge core_clk);
		row_clk[0] <= s[4];
		repeat (3) @(posedge core_clk);
		chk({28'h0, cell_out[0]}, {28'h0, s[3:0]});
		row_clk[0] <= 1'b0;
		@(posedge core_clk);
	endtask

	initial begin
		repeat (6) @(posedge core_clk);
		reset_n <= 1'b1;
		@(posedge core_clk);
		rd(CLK_CFG_OFS, 32'hffffffff, RESET_WORD, RESP_OKAY);
		rd(CTL_CFG_OFS, 32'hffffffff, RESET_WORD, RESP_OKAY);
		wr(STATUS_OFS, 32'h1, RESP_DECERR);
		wr(8'h01, 32'h1, RESP_DECERR);
		rd(8'h10, 32'hffffffff, 32'h0, RESP_DECERR);
		done("register map");
		for (int m = 0; m < 4; m++) begin
			wr(CELL_CFG_OFS + 8'h04, 32'(m), RESP_OKAY);
			rd(CELL_CFG_OFS + 8'h04, 32'h3, 32'(m), RESP_OKAY);
		end
		done("cell modes");
		// Three enabled lines on three different row clocks
		wr(CLK_CFG_OFS, 32'h7210, RESP_OKAY);
		rd(STATUS_OFS, 32'h20, 32'h20, RESP_OKAY);
		wr(CLK_CFG_OFS, 32'h7010, RESP_OKAY);
		rd(STATUS_OFS, 32'h20, 32'h0, RESP_OKAY);
		done("source limit");
		// Line 0 on row clock 0 rising, gated by local control 0
		// Gate-use enables live in the control word, bits 8 to 10
		wr(CLK_CFG_OFS, 32'h1000, RESP_OKAY);
		wr(CTL_CFG_OFS, 32'h1e8, RESP_OKAY);
		wr(CELL_CFG_OFS, 32'h0106_6800, RESP_OKAY);
		wr(LUT_OFS, 32'haaaa_aaaa, RESP_OKAY);
		wr(LUT_OFS + 8'h04, 32'h0, RESP_OKAY);
		wr(LUT_OFS + 8'h08, 32'hcccc_cccc, RESP_OKAY);
		wr(LUT_OFS + 8'h0c, 32'h0, RESP_OKAY);
		foreach (STEPS[i]) step(STEPS[i]);
		// Only cell 0 register 0 was preset; every other register is clear
		rd(REG_Q_OFS, 32'hffff, 32'h1, RESP_OKAY);
		done("cell registers");
		// Register 1 asks for f1 packing while register 0 stores the result
		wr(CELL_CFG_OFS, 32'h0106_e800, RESP_OKAY);
		rd(STATUS_OFS, 32'hff00, 32'h100, RESP_OKAY);
		done("packing refusal");
		end_of_test();
	end

	initial begin
		repeat (4000) @(posedge core_clk);
		mismatches++;
		end_of_test();
	end
endmodule
